// ### boot_strap_config_select.sv
// Purpose: samples strap and hall pins at power-up and fixes configuration
// Assumes: straps are synchronous to ref_clk and stable during power-up
// Notes:   a stored program and the motor supply are reported by inputs
`timescale 1ns/1ps

// How it works
// - all halls grounded invalidates setup table
// - invalid setup sets error bit 2, defaults
// - non-ethernet vendor can protocol autoruns by default
// - autorun starts valid program at motor on
// - nvm word 0x0001 at 0x2000 skips autorun
// - halls held grounded one second: slave mode
// - no valid program means slave mode
// - grounded protocol strap selects canopen
// - open protocol strap selects vendor can
// - software node identifier accepted 1 to 255
// - strap open reads 0, grounded 1
// - can identifier 1 to 127, open 255
// - straps sampled once at power-up
// - canopen identifier 255 means non-configured
// - non-configured: only layer-setting, no boot-up
// - invalid setup uses hardware strap identifier
// - ethernet variant copies identifier to alias
// - ethernet identifier is 8-bit, open 255
// - ethernet identifier 255 gives alias 0
module boot_strap_config_select
  import boot_cfg_pkg::*;
#(
  parameter int HALLS    = 3,
  parameter int HOLD_CNT = HOLD_CYC
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // strap and sensor pins, high when grounded
  input  wire logic [HALLS-1:0] hall_grounded,
  input  wire logic             proto_grounded,
  input  wire logic             eth_variant,
  input  wire logic [7:0]       id_grounded,
  // drive status
  input  wire logic             program_valid,
  input  wire logic             motor_supply_on,
  input  wire logic             layer_cmd,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  // configuration outputs
  output boot_cfg_t             cfg,
  output logic      [7:0]       station_alias,
  output logic                  program_start,
  output logic                  bus_tx_enable,
  output logic                  cmd_accept
);

  boot_phase_t phase;
  logic [31:0] hold_cnt;
  logic        halls_low;
  logic        hold_seen;
  logic [7:0]  hw_id;
  logic [7:0]  sw_id;
  logic        use_sw_id;
  logic [15:0] nvm_word;
  logic [15:0] motion_error;
  logic        sampled;
  logic        program_run;
  logic        next_start;

  function automatic logic [7:0] id_from_straps(input logic [7:0] pins,
                                                input logic       eth);
    logic [7:0] v;
    v = pins;
    if (!eth)
      v = {1'b0, pins[6:0]};
    if (v == 8'h00)
      v = ID_UNSET;
    return v;
  endfunction

  function automatic logic unconfigured(input boot_cfg_t c);
    return c.canopen && c.node_identifier == ID_UNSET;
  endfunction

  assign halls_low = &hall_grounded;

  // power-up sampling sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= PH_SETTLE;
      hold_cnt  <= '0;
      hold_seen <= 1'b0;
    end else begin
      unique case (phase)
        PH_SETTLE: begin
          hold_cnt <= hold_cnt + 32'h1;
          if (hold_cnt == 32'(SETTLE_CYC - 1)) begin
            hold_cnt <= '0;
            phase    <= halls_low ? PH_HOLD : PH_DONE;
          end
        end
        PH_HOLD: begin
          if (!halls_low) begin
            phase <= PH_DONE;
          end else if (hold_cnt == 32'(HOLD_CNT - 1)) begin
            hold_seen <= 1'b1;
            phase     <= PH_DONE;
          end else begin
            hold_cnt <= hold_cnt + 32'h1;
          end
        end
        PH_DONE: begin
          hold_cnt <= hold_cnt;
        end
        default: begin
          phase <= PH_DONE;
        end
      endcase
    end
  end

  // one-time capture of straps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled          <= 1'b0;
      cfg              <= '0;
      station_alias    <= ALIAS_NONE;
      motion_error     <= '0;
    end else if (phase == PH_SETTLE && hold_cnt == 32'(SETTLE_CYC - 1)
                 && !sampled) begin
      sampled              <= 1'b1;
      cfg.setup_valid      <= !halls_low;
      cfg.canopen          <= proto_grounded;
      cfg.eth_variant      <= eth_variant;
      cfg.autorun          <= !proto_grounded && !eth_variant;
      motion_error[SETUP_BAD_BIT] <= halls_low;
      // invalid setup forces hardware id
      if (halls_low || !use_sw_id)
        cfg.node_identifier <= id_from_straps(id_grounded,
                                              eth_variant);
      else
        cfg.node_identifier <= sw_id;
      if (eth_variant) begin
        if (halls_low || !use_sw_id)
          station_alias <= (id_from_straps(id_grounded, 1'b1) == ID_UNSET)
                           ? ALIAS_NONE
                           : id_from_straps(id_grounded, 1'b1);
        else
          station_alias <= (sw_id == ID_UNSET) ? ALIAS_NONE : sw_id;
      end
    end else if (hold_seen) begin
      cfg.autorun <= 1'b0;
    end
  end

  // software-set identifier and nvm word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_id     <= 8'h01;
      use_sw_id <= 1'b0;
      nvm_word  <= NVM_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_SW_ID && reg_wdata[7:0] != 8'h00)
        sw_id <= reg_wdata[7:0];
      if (reg_addr == OFS_CONTROL)
        use_sw_id <= reg_wdata[CTL_USE_SW_ID];
      if (reg_addr == OFS_NVM_WORD)
        nvm_word <= reg_wdata;
    end
  end

  // autorun start decision
  always_comb begin
    next_start = cfg.autorun && !cfg.canopen
                 && program_valid
                 && nvm_word != AUTORUN_OFF
                 && motor_supply_on && phase == PH_DONE && !program_run;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_start <= 1'b0;
      program_run   <= 1'b0;
    end else begin
      program_start <= next_start;
      if (next_start)
        program_run <= 1'b1;
    end
  end

  // non-configured canopen gating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_tx_enable <= 1'b0;
      cmd_accept    <= 1'b0;
    end else if (phase != PH_DONE) begin
      bus_tx_enable <= 1'b0;
      cmd_accept    <= 1'b0;
    end else if (unconfigured(cfg)) begin
      bus_tx_enable <= 1'b0;
      cmd_accept    <= layer_cmd;
    end else begin
      bus_tx_enable <= 1'b1;
      cmd_accept    <= 1'b1;
    end
  end

  // register read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_STATUS:    reg_rdata <= {9'h000, cfg.eth_variant,
                                     phase == PH_DONE, program_run,
                                     unconfigured(cfg),
                                     cfg.autorun, cfg.canopen,
                                     cfg.setup_valid};
        OFS_NODE_ID:   reg_rdata <= {8'h00, cfg.node_identifier};
        OFS_SW_ID:     reg_rdata <= {8'h00, sw_id};
        OFS_NVM_WORD:  reg_rdata <= nvm_word;
        OFS_ALIAS:     reg_rdata <= {8'h00, station_alias};
        OFS_MOTION_ER: reg_rdata <= motion_error;
        OFS_CONTROL:   reg_rdata <= {15'h0000, use_sw_id};
        default:       reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // checks
  setup_invalid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled) |-> cfg.setup_valid == !$past(halls_low))
    else $error("setup valid not from hall level");
  error_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && !cfg.setup_valid |-> motion_error[2])
    else $error("error bit 2 missing");
  canopen_noauto_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.canopen |-> !program_start)
    else $error("autostart under canopen");
  nvm_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(nvm_word) == 16'h0001 |-> !program_start)
    else $error("autostart despite disable word");
  no_program_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(program_valid) |-> !program_start)
    else $error("start without valid program");
  can_id_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled) && !cfg.eth_variant && !use_sw_id
    |-> cfg.node_identifier <= 8'h7F || cfg.node_identifier == 8'hFF)
    else $error("can identifier out of range");
  alias_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && cfg.eth_variant && cfg.node_identifier == 8'hFF
    |-> station_alias == 8'h00)
    else $error("alias not zero for id 255");
  frozen_cfg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && $past(sampled) && !hold_seen |-> $stable(cfg))
    else $error("configuration changed after sampling");
  unconfig_tx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.canopen && cfg.node_identifier == 8'hFF |=> !bus_tx_enable)
    else $error("transmit while not configured");
  hold_slave_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hold_seen) |=> !cfg.autorun)
    else $error("autorun after hall hold");
  sample_once_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    sampled |=> sampled)
    else $error("sampling flag dropped");
  proto_ground_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled) && $past(proto_grounded) |-> cfg.canopen)
    else $error("grounded strap did not select canopen");
  proto_open_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled) && !$past(proto_grounded) |-> !cfg.canopen)
    else $error("open strap did not select vendor can");
  can_autorun_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled)
    |-> cfg.autorun == (!$past(proto_grounded) && !$past(eth_variant)))
    else $error("autorun default wrong");
  start_pulse_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    program_start |=> !program_start)
    else $error("program start longer than one cycle");
  start_cause_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    program_start |-> $past(motor_supply_on) && $past(program_valid))
    else $error("start without motor supply");
  sw_id_range_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    sw_id != 8'h00)
    else $error("software identifier zero");
  sw_id_keep_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_SW_ID && reg_wdata[7:0] == 8'h00
    |=> $stable(sw_id))
    else $error("zero software identifier taken");
  eth_id_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled) && cfg.eth_variant |-> cfg.node_identifier != 8'h00)
    else $error("ethernet identifier zero");
  alias_copy_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && cfg.eth_variant && cfg.node_identifier != ID_UNSET
    |-> station_alias == cfg.node_identifier)
    else $error("alias differs from identifier");
  hw_id_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled) && !cfg.setup_valid && !cfg.eth_variant
    |-> cfg.node_identifier == (($past(id_grounded[6:0]) == 7'h00)
        ? ID_UNSET : {1'b0, $past(id_grounded[6:0])}))
    else $error("invalid setup did not use strap identifier");
  error_clear_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && cfg.setup_valid |-> !motion_error[SETUP_BAD_BIT])
    else $error("error bit set with valid setup");
  unconfig_cmd_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    phase == PH_DONE && unconfigured(cfg) |=> cmd_accept == $past(layer_cmd))
    else $error("non-layer command accepted");
  configured_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    phase == PH_DONE && !unconfigured(cfg) |=> bus_tx_enable && cmd_accept)
    else $error("configured node silent");
  halls_held_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hold_seen) |-> $past(halls_low))
    else $error("hold seen without grounded halls");
  hold_bound_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    phase == PH_HOLD |-> hold_cnt < 32'(HOLD_CNT))
    else $error("hold counter overran");
  alias_frozen_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && $past(sampled) |-> $stable(station_alias) && $stable(motion_error))
    else $error("alias or error changed after sampling");
  eth_noauto_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.eth_variant |-> !cfg.autorun)
    else $error("autorun on ethernet variant");
  quiet_early_a:
    assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sampled |-> !program_start && !bus_tx_enable)
    else $error("activity before sampling");

  autostart_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    program_start);
  unconfig_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && cfg.canopen && cfg.node_identifier == 8'hFF);
  invalid_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sampled) && !cfg.setup_valid);
  hold_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hold_seen));
  alias_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sampled && station_alias != 8'h00);

endmodule

// ### boot_cfg_pkg.sv
// Purpose: shared constants and types for the power-up strap loader
// Assumes: one clock domain, registers reached over a plain port
// Notes:   offsets are word indices on the plain register port
package boot_cfg_pkg;

  // register offsets
  localparam logic [3:0] OFS_STATUS    = 4'h0;
  localparam logic [3:0] OFS_NODE_ID   = 4'h1;
  localparam logic [3:0] OFS_SW_ID     = 4'h2;
  localparam logic [3:0] OFS_NVM_WORD  = 4'h3;
  localparam logic [3:0] OFS_ALIAS     = 4'h4;
  localparam logic [3:0] OFS_MOTION_ER = 4'h5;
  localparam logic [3:0] OFS_CONTROL   = 4'h6;

  // field positions
  localparam int SETUP_BAD_BIT  = 2;
  localparam int ST_SETUP_VALID = 0;
  localparam int ST_CANOPEN     = 1;
  localparam int ST_AUTORUN     = 2;
  localparam int ST_UNCONFIG    = 3;
  localparam int ST_RUNNING     = 4;
  localparam int ST_DONE        = 5;
  localparam int ST_ETH         = 6;
  localparam int CTL_USE_SW_ID  = 0;

  // values
  localparam logic [15:0] AUTORUN_OFF   = 16'h0001;
  localparam logic [15:0] NVM_AUTO_ADDR = 16'h2000;
  localparam logic [7:0]  ID_UNSET      = 8'hFF;
  localparam logic [7:0]  ID_CAN_MAX    = 8'h7F;
  localparam logic [7:0]  ALIAS_NONE    = 8'h00;
  localparam logic [15:0] NVM_RESET     = 16'h0000;

  // hall hold time after strap sampling, settle time before it
  localparam int HOLD_MS  = 1000;
  localparam int CLK_MHZ  = 250;
  localparam longint HOLD_CYC_L = longint'(HOLD_MS) * 1000 * CLK_MHZ;
  localparam int HOLD_CYC = int'(HOLD_CYC_L);
  localparam int SETTLE_CYC = 4;

  typedef struct packed {
    logic       setup_valid;
    logic       canopen;
    logic       eth_variant;
    logic       autorun;
    logic [7:0] node_identifier;
  } boot_cfg_t;

  typedef enum logic [1:0] {
    PH_SETTLE,
    PH_HOLD,
    PH_DONE
  } boot_phase_t;

endpackage

// ### strap_board.sv
// Purpose: board straps and layer-setting master beside the loader
// Assumes: a hall line reads 1 while grounded
// Notes:   halls let go once the power-on hold is over
`timescale 1ns/1ps
module strap_board #(
  parameter int HALLS = 3,
  parameter int HOLD  = 20
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // board setup
  input  wire logic             hold_halls,
  // pins toward the drive
  output logic      [HALLS-1:0] hall_grounded,
  output logic                  layer_cmd
);
  int cnt;

  // power-on age and a layer command every other cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 0;
      layer_cmd <= 1'b0;
    end else begin
      if (cnt < HOLD + 40) begin
        cnt <= cnt + 1;
      end
      layer_cmd <= ~layer_cmd;
    end
  end

  // grounded through power-on, released past the hold
  assign hall_grounded = (hold_halls && cnt < HOLD + 12) ? '1 : '0;
endmodule

// ### tb.sv
// Purpose: bench for the power-up strap loader
// Assumes: hall hold shortened to HC cycles
// Notes:   one power-on per scenario
`timescale 1ns/1ps
module tb
  import boot_cfg_pkg::*;
;
  localparam int HC = 20;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hold = 1'b0;
  logic        proto_grounded = 1'b0;
  logic        eth_variant = 1'b0;
  logic        program_valid = 1'b0;
  logic        motor_supply_on = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  id_grounded = 8'h00;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] prev;
  logic [7:0]  station_alias;
  logic [2:0]  hall_grounded;
  logic        layer_cmd;
  logic        program_start;
  logic        bus_tx_enable;
  logic        cmd_accept;
  boot_cfg_t   cfg;
  int          fail_count = 0;
  int          comparisons = 0;
  int          starts = 0;
  int          cyc = 0;

  always #2 ref_clk = ~ref_clk;

  strap_board #(.HOLD(HC)) u_board (.ref_clk, .rst_n, .hold_halls(hold),
    .hall_grounded, .layer_cmd);
  boot_strap_config_select #(.HOLD_CNT(HC)) u_dut (.ref_clk, .rst_n,
    .hall_grounded, .proto_grounded, .eth_variant, .id_grounded,
    .program_valid, .motor_supply_on, .layer_cmd, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cfg, .station_alias, .program_start,
    .bus_tx_enable, .cmd_accept);

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // start pulses and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (program_start === 1'b1) starts++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] ex(logic v, logic c, logic e, logic a,
                                     logic [7:0] n);
    return {4'h0, v, c, e, a, n};
  endfunction

  task automatic wr(logic [3:0] a, logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask

  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(logic [3:0] a, logic [15:0] exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge ref_clk);
  endtask

  // power cycle with given straps, optional software id before sampling
  task automatic boot(logic h, logic p, logic e, logic [7:0] id,
                      logic pv, logic [7:0] sw);
    rst_n           <= 1'b0;
    hold            <= h;
    proto_grounded  <= p;
    eth_variant     <= e;
    id_grounded     <= id;
    program_valid   <= pv;
    motor_supply_on <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    starts = 0;
    if (sw != 8'h00) begin
      wr(OFS_SW_ID, {8'h00, sw});
      wr(OFS_SW_ID, 16'h0000);
      wr(OFS_CONTROL, 16'h0001);
    end
    idle();
    repeat (HC + 40) @(posedge ref_clk);
  endtask

  task automatic motor(int n);
    motor_supply_on <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(16'(starts), 16'(n));
  endtask

  initial begin
    boot(1'b0, 1'b0, 1'b0, 8'h85, 1'b1, 8'h00);
    chk(16'(cfg), ex(1'b1, 1'b0, 1'b0, 1'b1, 8'h05));
    rd(OFS_MOTION_ER, 16'h0000);
    chk({15'h0, bus_tx_enable}, 16'h0001);
    chk({15'h0, cmd_accept}, 16'h0001);
    motor(1);
    id_grounded    <= 8'h33;
    proto_grounded <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(16'(cfg), ex(1'b1, 1'b0, 1'b0, 1'b1, 8'h05));
    rd(OFS_NODE_ID, 16'h0005);
    boot(1'b0, 1'b0, 1'b0, 8'h05, 1'b1, 8'h00);
    wr(OFS_NVM_WORD, AUTORUN_OFF);
    idle();
    rd(OFS_NVM_WORD, AUTORUN_OFF);
    motor(0);
    boot(1'b0, 1'b0, 1'b0, 8'h05, 1'b0, 8'h00);
    motor(0);
    boot(1'b0, 1'b1, 1'b0, 8'h00, 1'b1, 8'h00);
    chk(16'(cfg), ex(1'b1, 1'b1, 1'b0, 1'b0, 8'hFF));
    chk({15'h0, bus_tx_enable}, 16'h0000);
    rd(OFS_STATUS, 16'h002B);
    repeat (4) begin
      #1 prev = {15'h0, layer_cmd};
      @(posedge ref_clk);
      #1 chk({15'h0, cmd_accept}, prev);
    end
    motor(0);
    boot(1'b1, 1'b0, 1'b0, 8'h0A, 1'b1, 8'hC8);
    chk(16'(cfg), ex(1'b0, 1'b0, 1'b0, 1'b0, 8'h0A));
    rd(OFS_MOTION_ER, 16'h0004);
    motor(0);
    boot(1'b0, 1'b0, 1'b1, 8'hA5, 1'b0, 8'h00);
    chk(16'(cfg), ex(1'b1, 1'b0, 1'b1, 1'b0, 8'hA5));
    rd(OFS_ALIAS, 16'h00A5);
    boot(1'b0, 1'b0, 1'b1, 8'h00, 1'b0, 8'h00);
    chk(16'(cfg), ex(1'b1, 1'b0, 1'b1, 1'b0, 8'hFF));
    chk({8'h00, station_alias}, 16'h0000);
    boot(1'b0, 1'b0, 1'b0, 8'h05, 1'b1, 8'hC8);
    chk(16'(cfg), ex(1'b1, 1'b0, 1'b0, 1'b1, 8'hC8));
    rd(OFS_SW_ID, 16'h00C8);
    rd(OFS_CONTROL, 16'h0001);
    rd(OFS_STATUS, 16'h0025);
    rd(4'hF, 16'h0000);
    results();
  end
endmodule
